/* rtl/shp_pkg.sv */
// Shared constants and types for the serial host register port
package shp_pkg;

  // Register space shape
  localparam int unsigned REG_AW = 7;
  localparam int unsigned REG_DW = 8;
  localparam logic [REG_AW-1:0] PTR_STEP = 7'h01;
  localparam logic [REG_AW-1:0] PTR_RST = 7'h00;

  // Two-wire target address, upper six bits fixed
  localparam logic [5:0] I2C_ADDR_HI = 6'h34;

  // Configuration register holding the two-wire disable bit
  localparam logic [REG_AW-1:0] CFG_IDX = 7'h6A;
  localparam int unsigned CFG_TWO_WIRE_OFF_BIT = 4;

  // Bit counters
  localparam int unsigned I2C_BW = 4;
  localparam logic [I2C_BW-1:0] I2C_BYTE_BITS = 4'h8;
  localparam logic [I2C_BW-1:0] I2C_BIT_STEP = 4'h1;
  localparam logic [I2C_BW-1:0] I2C_BIT_RST = 4'h0;
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;
  localparam logic [2:0] SPI_BIT_STEP = 3'h1;
  localparam logic [2:0] SPI_BIT_RST = 3'h0;

  // Field positions
  localparam int unsigned MSB = REG_DW - 1;
  localparam int unsigned CMD_RW_BIT = 7;

  // Link clock period seen in the bench, informational
  localparam int unsigned LINK_PERIOD_NS = 160;

  // Two-wire protocol states
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ADDR_ACK = 3'b010,
    I2C_RX = 3'b011,
    I2C_RX_ACK = 3'b100,
    I2C_TX = 3'b101,
    I2C_TX_ACK = 3'b110
  } shp_i2c_e;

  // Synchronised pin levels
  typedef struct packed {
    logic strap;
    logic cs_n;
    logic sda;
    logic scl;
  } shp_pins_s;

  localparam shp_pins_s PINS_RST = 4'h7;

  // Register write event toward the sensor core
  typedef struct packed {
    logic en;
    logic [REG_AW-1:0] idx;
    logic [REG_DW-1:0] data;
  } shp_wr_s;

endpackage

/* rtl/shp_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module shp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage, read only by the second
  logic [W-1:0] meta_q;

  // Two flops per bit
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* rtl/shp_regfile.sv */
// Byte-wide register array with one write and one read port
`timescale 1ns/1ps
module shp_regfile #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  // Storage, contents undefined until written
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read port is combinational
  assign rdata = mem[raddr];

endmodule

/* rtl/shp_serial_port.sv */
// Two-wire and four-wire slave port into the register array
`timescale 1ns/1ps
module shp_serial_port
  import shp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_sclk_i,
  input wire logic sda_sdi_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic cs_n_i,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic low_id_strap_i,
  output logic two_wire_port_off,
  output shp_wr_s wr_o
);

  // Synchronised pins and previous samples
  shp_pins_s pins_s;
  logic scl_p_q;
  logic sda_p_q;
  logic strap_q;

  // Two-wire engine state
  shp_i2c_e st_q;
  logic [I2C_BW-1:0] bit_q;
  logic [REG_DW-1:0] sh_q;
  logic idx_pend_q;
  logic rw_q;
  logic mack_q;
  logic sda_oe_q;

  // Four-wire engine state
  logic [2:0] sbit_q;
  logic [REG_DW-1:0] ssh_q;
  logic [REG_DW-1:0] stx_q;
  logic spi_first_q;
  logic spi_rd_q;
  logic sdo_oe_q;

  // Shared pointer, config and write event
  logic [REG_AW-1:0] ptr_q;
  logic two_wire_off_q;
  shp_wr_s wr_q;

  // Register array read data
  logic [REG_DW-1:0] rdata;

  // All pins pass two flops first
  shp_sync #(.W(4), .RST(PINS_RST)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({low_id_strap_i, cs_n_i, sda_sdi_i, scl_sclk_i}),
    .q(pins_s)
  );

  // Edge and condition decode
  wire scl_rise = pins_s.scl & ~scl_p_q;
  wire scl_fall = ~pins_s.scl & scl_p_q;
  wire scl_held = pins_s.scl & scl_p_q;
  wire i2c_en = ~two_wire_off_q & pins_s.cs_n;
  wire start_det = i2c_en & scl_held & sda_p_q & ~pins_s.sda;
  wire stop_det = i2c_en & scl_held & ~sda_p_q & pins_s.sda;
  wire addr_hit = sh_q[MSB:1] == {I2C_ADDR_HI, strap_q};
  wire byte_end = scl_fall & (bit_q == I2C_BYTE_BITS);
  wire rd_msb = rdata[MSB];

  // Two-wire byte completion events
  wire i2c_rx_done = i2c_en & (st_q == I2C_RX) & byte_end;
  wire i2c_idx_ld = i2c_rx_done & idx_pend_q;
  wire i2c_wr = i2c_rx_done & ~idx_pend_q;
  wire i2c_tx_done = i2c_en & (st_q == I2C_TX) & byte_end;

  // Four-wire decode
  wire spi_act = ~pins_s.cs_n;
  wire [REG_DW-1:0] spi_rx_byte = {ssh_q[MSB-1:0], pins_s.sda};
  wire [REG_AW-1:0] spi_cmd_idx = spi_rx_byte[REG_AW-1:0];
  wire spi_byte = spi_act & scl_rise & (sbit_q == SPI_LAST_BIT);
  wire spi_cmd = spi_byte & spi_first_q;
  wire spi_wr = spi_byte & ~spi_first_q & ~spi_rd_q;
  wire spi_rd_adv = spi_byte & ~spi_first_q & spi_rd_q;
  wire spi_load = spi_act & scl_fall & (sbit_q == SPI_BIT_RST) & ~spi_first_q & spi_rd_q;

  // Pointer and write selection
  wire ptr_load = i2c_idx_ld | spi_cmd;
  wire [REG_AW-1:0] ptr_ld_val = spi_cmd ? spi_cmd_idx : sh_q[REG_AW-1:0];
  wire ptr_inc = i2c_wr | i2c_tx_done | spi_wr | spi_rd_adv;
  wire wr_en = i2c_wr | spi_wr;
  wire [REG_DW-1:0] wr_data = spi_wr ? spi_rx_byte : sh_q;
  wire cfg_hit = wr_en & (ptr_q == CFG_IDX);

  // Register storage
  shp_regfile #(.AW(REG_AW), .DW(REG_DW)) u_regs (
    .clk(clk),
    .we(wr_en),
    .waddr(ptr_q),
    .wdata(wr_data),
    .raddr(ptr_q),
    .rdata(rdata)
  );

  // Previous pin levels and strap capture
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      strap_q <= 1'b0;
    end else begin
      scl_p_q <= pins_s.scl;
      sda_p_q <= pins_s.sda;
      strap_q <= pins_s.strap;
    end
  end

  // Two-wire protocol engine
  always_ff @(posedge clk) begin
    if (srst || !i2c_en || stop_det) begin
      // Idle, line released
      st_q <= I2C_IDLE;
      bit_q <= I2C_BIT_RST;
      sda_oe_q <= 1'b0;
      mack_q <= 1'b0;
      if (srst) begin
        sh_q <= '0;
        idx_pend_q <= 1'b0;
        rw_q <= 1'b0;
      end
    end else if (start_det) begin
      // START or repeated START, expect address
      st_q <= I2C_ADDR;
      bit_q <= I2C_BIT_RST;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        I2C_IDLE: begin
          // Wait for START
        end
        I2C_ADDR, I2C_RX: begin
          if (scl_rise) begin
            // Sample on clock high
            sh_q <= {sh_q[MSB-1:0], pins_s.sda};
            bit_q <= bit_q + I2C_BIT_STEP;
          end else if (byte_end) begin
            bit_q <= I2C_BIT_RST;
            if (st_q == I2C_RX) begin
              // Index or data byte taken, pull low for ack
              st_q <= I2C_RX_ACK;
              sda_oe_q <= 1'b1;
              idx_pend_q <= 1'b0;
            end else if (addr_hit) begin
              // Own address, acknowledge
              st_q <= I2C_ADDR_ACK;
              sda_oe_q <= 1'b1;
              rw_q <= sh_q[0];
            end else begin
              // Other target, stay off the line
              st_q <= I2C_IDLE;
            end
          end
        end
        I2C_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              // Read: first byte, MSB on the line
              st_q <= I2C_TX;
              sh_q <= rdata;
              sda_oe_q <= ~rd_msb;
            end else begin
              // Write: next byte is the index
              st_q <= I2C_RX;
              sda_oe_q <= 1'b0;
              idx_pend_q <= 1'b1;
            end
          end
        end
        I2C_RX_ACK: begin
          if (scl_fall) begin
            // Release after ack clock, more bytes may follow
            st_q <= I2C_RX;
            sda_oe_q <= 1'b0;
          end
        end
        I2C_TX: begin
          if (scl_rise) begin
            bit_q <= bit_q + I2C_BIT_STEP;
          end else if (byte_end) begin
            // Release for the master's ack slot
            st_q <= I2C_TX_ACK;
            bit_q <= I2C_BIT_RST;
            sda_oe_q <= 1'b0;
          end else if (scl_fall) begin
            // Next bit while clock low
            sh_q <= {sh_q[MSB-1:0], 1'b0};
            sda_oe_q <= ~sh_q[MSB-1];
          end
        end
        I2C_TX_ACK: begin
          if (scl_rise) begin
            // Low means ack, high means nack
            mack_q <= ~pins_s.sda;
          end else if (scl_fall) begin
            if (mack_q) begin
              // Next register already addressed
              st_q <= I2C_TX;
              sh_q <= rdata;
              sda_oe_q <= ~rd_msb;
            end else begin
              // Nack: stop driving, wait for STOP
              st_q <= I2C_IDLE;
            end
          end
        end
        default: begin
          st_q <= I2C_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Four-wire receive shifter and framing
  always_ff @(posedge clk) begin
    if (srst || !spi_act) begin
      // Deselected: new frame starts with command
      sbit_q <= SPI_BIT_RST;
      ssh_q <= '0;
      spi_first_q <= 1'b1;
      spi_rd_q <= 1'b0;
    end else if (scl_rise) begin
      // Sample on rising edge, MSB first
      ssh_q <= spi_rx_byte;
      sbit_q <= sbit_q + SPI_BIT_STEP;
      if (spi_cmd) begin
        // Command byte: top bit read, rest index
        spi_first_q <= 1'b0;
        spi_rd_q <= spi_rx_byte[CMD_RW_BIT];
      end
    end
  end

  // Four-wire transmit shifter and output enable
  always_ff @(posedge clk) begin
    if (srst) begin
      stx_q <= '0;
      sdo_oe_q <= 1'b0;
    end else begin
      // Drive only while selected in a read
      sdo_oe_q <= spi_act & spi_rd_q & ~spi_first_q;
      if (spi_load) begin
        // Byte boundary: fetch current register
        stx_q <= rdata;
      end else if (spi_act && scl_fall) begin
        // Change data on falling edge
        stx_q <= {stx_q[MSB-1:0], 1'b0};
      end
    end
  end

  // Pointer, configuration and write event
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_q <= PTR_RST;
      two_wire_off_q <= 1'b0;
      wr_q <= '0;
    end else begin
      wr_q <= '{en: wr_en, idx: ptr_q, data: wr_data};
      if (ptr_load) begin
        ptr_q <= ptr_ld_val;
      end else if (ptr_inc) begin
        // Auto-increment per data byte
        ptr_q <= ptr_q + PTR_STEP;
      end
      if (cfg_hit) begin
        // Host may switch the two-wire engine off
        two_wire_off_q <= wr_data[CFG_TWO_WIRE_OFF_BIT];
      end
    end
  end

  // Outputs from flops except sda_o, tied low; open-drain line only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign sdo_o = stx_q[MSB];
  assign sdo_oe = sdo_oe_q;
  assign two_wire_port_off = two_wire_off_q;
  assign wr_o = wr_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_ack_drives_low: assert property (
    ((st_q == I2C_ADDR_ACK) || (st_q == I2C_RX_ACK)) && pins_s.scl |-> sda_oe_q
  ) else $error("ack slot not held low");

  a_sda_moves_low: assert property (
    !start_det && !stop_det && $changed(sda_oe_q) |-> !pins_s.scl
  ) else $error("data line changed while clock high");

  a_addr_strap_match: assert property (
    $rose(st_q == I2C_ADDR_ACK) |-> sh_q[MSB:1] == {I2C_ADDR_HI, strap_q}
  ) else $error("acknowledged a foreign address");

  a_write_next_reg: assert property (
    wr_q.en |-> (ptr_q == wr_q.idx + PTR_STEP) && ($past(ptr_q) == wr_q.idx)
  ) else $error("write did not advance pointer");

  a_read_advances: assert property (
    i2c_tx_done |=> ptr_q == $past(ptr_q) + PTR_STEP
  ) else $error("read did not advance pointer");

  a_nack_goes_idle: assert property (
    (st_q == I2C_TX_ACK) && scl_fall && !mack_q && !start_det && !stop_det
      |=> (st_q == I2C_IDLE) && !sda_oe_q
  ) else $error("nack did not end the read");

  a_sdo_hiz_desel: assert property (
    pins_s.cs_n |=> !sdo_oe_q ##1 !sdo_oe_q || !pins_s.cs_n
  ) else $error("output driven while deselected");

  a_spi_cmd_index: assert property (
    spi_cmd |=> (ptr_q == $past(spi_cmd_idx)) && !spi_first_q
  ) else $error("command index not loaded");

  a_spi_msb_first: assert property (
    spi_load |=> sdo_o == $past(rd_msb)
  ) else $error("read byte not MSB first");

  c_i2c_write: cover property (i2c_wr ##[1:1000] stop_det);
  c_i2c_burst_read: cover property (i2c_tx_done ##[1:1000] i2c_tx_done);
  c_spi_read: cover property (spi_cmd && spi_rx_byte[CMD_RW_BIT] ##[1:1000] spi_rd_adv);
  c_two_wire_off: cover property ($rose(two_wire_off_q));

endmodule

/* verif/shp_host_model.sv */
// Host master model driving the two-wire and four-wire pins
`timescale 1ns/1ps
module shp_host_model (
  input wire logic clk,
  input wire logic sda_line,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  output logic scl,
  output logic sda_low,
  output logic cs_n
);
  logic sdo_last_q; // Last level the device drove on SDO
  logic sdo_line; // SDO as seen by the host

  // Remember the driven level so an undriven line can differ from it
  always @(posedge clk) begin
    if (sdo_oe) begin
      sdo_last_q <= sdo_o;
    end
  end
  // A released SDO shows the inverse of its last level, never a stale copy
  assign sdo_line = sdo_oe ? sdo_o : ~sdo_last_q;

  // Bus idle: clock high, data released, device deselected
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
    cs_n = 1'h1;
    sdo_last_q = 1'h0;
  end

  // One two-wire bit: data set while clock low, read back mid-high
  task automatic bit_io(input logic b, output logic r);
    #20 sda_low = ~b;
    #60 scl = 1'h1;
    #40 r = sda_line;
    #40 scl = 1'h0;
  endtask

  // START from idle, or repeated START from a low clock
  task automatic i2c_start();
    if (scl === 1'h0) begin
      #20 sda_low = 1'h0;
      #60 scl = 1'h1;
    end
    #80 sda_low = 1'h1;
    #80 scl = 1'h0;
  endtask

  // STOP, then the clock stands still high
  task automatic i2c_stop();
    #20 sda_low = 1'h1;
    #60 scl = 1'h1;
    #80 sda_low = 1'h0;
    #160;
  endtask

  // Eight bits most significant first, then the acknowledge slot
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in,
                          output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack_out);
  endtask

  // Select the device for one four-wire transaction
  task automatic spi_begin();
    cs_n = 1'h0;
    #80;
  endtask

  // Data changes after the fall, is taken after the rise
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      scl = 1'h0;
      #20 sda_low = ~tx[i];
      #60 scl = 1'h1; // Fixed bench link period
      #40 rx[i] = sdo_line;
      #40;
    end
  endtask

  // Release data first so no two-wire condition is seen while selected
  task automatic spi_end();
    sda_low = 1'h0;
    #80 cs_n = 1'h1;
    #160;
  endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the serial host register port
`timescale 1ns/1ps
module tb;
  import shp_pkg::*;
  logic clk, srst, strap, sda_line, scl, sda_low, cs_n;
  logic sda_o, sda_oe, sdo_o, sdo_oe, two_wire_port_off;
  shp_wr_s wr_o;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed;
  logic [6:0] base; // Random four-wire start index
  logic [7:0] force_or = 8'h00; // Bits forced into random write data
  logic [7:0] mem [128]; // Expected register contents
  logic [14:0] wr_q [$]; // Stores seen at the port
  logic [14:0] exp_q [$]; // Stores expected

  // System clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // Open-drain data wire with pull-up
  assign sda_line = (sda_low | (sda_oe & ~sda_o)) ? 1'h0 : 1'h1;

  shp_serial_port i_dut (.clk(clk), .srst(srst), .scl_sclk_i(scl), .sda_sdi_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .cs_n_i(cs_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .low_id_strap_i(strap), .two_wire_port_off(two_wire_port_off), .wr_o(wr_o));
  shp_host_model i_host (.clk(clk), .sda_line(sda_line), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .scl(scl), .sda_low(sda_low), .cs_n(cs_n));

  // Capture every store pulse, and cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (wr_o.en === 1'h1) begin
      wr_q.push_back({wr_o.idx, wr_o.data});
    end
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Address byte with fixed high bits, strap and direction
  function automatic logic [7:0] addr_byte(input logic rd, input logic lsb);
    return {I2C_ADDR_HI, lsb, rd};
  endfunction
  // Command byte: direction on top, index below
  function automatic logic [7:0] spi_cmd(input logic rd, input logic [6:0] idx);
    return {rd, idx};
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, error_cnt);
  endtask

  // Compare store pulses against expected ones, then empty both
  task automatic chk_stores();
    logic [14:0] w, e;
    chk8(8'(wr_q.size()), 8'(exp_q.size()));
    while (wr_q.size() > 0 && exp_q.size() > 0) begin
      w = wr_q.pop_front();
      e = exp_q.pop_front();
      chk8({1'h0, w[14:8]}, {1'h0, e[14:8]});
      chk8(w[7:0], e[7:0]);
    end
    wr_q.delete();
    exp_q.delete();
  endtask

  // Synchronous reset for six cycles, outputs checked while held
  task automatic do_reset();
    @(posedge clk) #1 srst = 1'h1;
    repeat (6) @(posedge clk);
    #1 chk8({sda_oe, sdo_oe, two_wire_port_off, wr_o.en, 4'h0}, 8'h00);
    srst = 1'h0;
    repeat (4) @(posedge clk);
    // Keep the host off the clock edges
    #1;
  endtask

  // Two-wire write of n random bytes from idx
  task automatic i2c_write(input logic [6:0] idx, input int n, input logic lsb,
                           input logic acked);
    logic [7:0] rx, d;
    logic a;
    i_host.i2c_start();
    i_host.i2c_byte(addr_byte(1'h0, lsb), 1'h1, rx, a);
    chk1(a, ~acked);
    i_host.i2c_byte({1'h0, idx}, 1'h1, rx, a);
    chk1(a, ~acked);
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      i_host.i2c_byte(d, 1'h1, rx, a);
      chk1(a, ~acked);
      if (acked) begin
        mem[idx] = d;
        exp_q.push_back({idx, d});
      end
      idx = idx + PTR_STEP;
    end
    i_host.i2c_stop();
  endtask

  // Two-wire read of n bytes from idx, last one not acknowledged
  task automatic i2c_read(input logic [6:0] idx, input int n);
    logic [7:0] rx;
    logic a;
    i_host.i2c_start();
    i_host.i2c_byte(addr_byte(1'h0, strap), 1'h1, rx, a);
    chk1(a, 1'h0);
    i_host.i2c_byte({1'h0, idx}, 1'h1, rx, a);
    chk1(a, 1'h0);
    i_host.i2c_start();
    i_host.i2c_byte(addr_byte(1'h1, strap), 1'h1, rx, a);
    chk1(a, 1'h0);
    for (int k = 0; k < n; k++) begin
      i_host.i2c_byte(8'hFF, k == n - 1, rx, a);
      chk8(rx, mem[idx]);
      idx = idx + PTR_STEP;
    end
    i_host.i2c_stop();
  endtask

  // Four-wire transaction of n data bytes, read or write
  task automatic spi_xfer(input logic rd, input logic [6:0] idx, input int n);
    logic [7:0] rx, d;
    i_host.spi_begin();
    i_host.spi_byte(spi_cmd(rd, idx), rx);
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed)) | force_or;
      i_host.spi_byte(d, rx);
      if (rd) begin
        chk8(rx, mem[idx]);
      end else begin
        mem[idx] = d;
        exp_q.push_back({idx, d});
      end
      idx = idx + PTR_STEP;
    end
    i_host.spi_end();
    chk1(sdo_oe, 1'h0);
  endtask

  // Main sequence
  initial begin
    seed = 32'h45E4;
    srst = 1'h1;
    strap = 1'h0;
    #1 strap = 1'($random(seed));
    do_reset();
    end_test("reset");
    i2c_write(7'h7E, 4, strap, 1'h1);
    chk_stores();
    i2c_read(7'h7E, 4);
    end_test("two-wire burst with wrap");
    i2c_write(7'h20, 1, ~strap, 1'h0);
    chk_stores();
    end_test("foreign address");
    base = {3'h1, 4'($random(seed))};
    spi_xfer(1'h0, base, 3);
    spi_xfer(1'h0, 7'h05, 1);
    chk_stores();
    spi_xfer(1'h1, base, 3);
    spi_xfer(1'h1, 7'h05, 1);
    end_test("four-wire single and burst");
    force_or = 8'h10;
    spi_xfer(1'h0, CFG_IDX, 1);
    force_or = 8'h00;
    chk1(two_wire_port_off, 1'h1);
    i2c_write(7'h30, 1, strap, 1'h0);
    chk_stores();
    end_test("two-wire disabled");
    do_reset();
    chk1(two_wire_port_off, 1'h0);
    i2c_read(7'h00, 2);
    end_test("second reset");
    give_verdict();
  end

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
endmodule
